//--- hdl/cor_regs.sv
`timescale 1ns/1ps
`default_nettype none
module cor_regs
  import cor_pkg::*;
#(
  parameter int RAW_W = 12,
  parameter int BUS_W = 24
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [COR_ADR_W-1:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire cor_timing_s AUTO_TIMING,
  output cor_timing_s TX_TIMING,
  input wire logic [RAW_W-1:0] RAW_PIXEL,
  output logic [BUS_W-1:0] COLOUR_BUS,
  output cor_port_s PORT0_CFG,
  output cor_port_s PORT1_CFG,
  output logic [COR_VC_W-1:0] VIRTUAL_CHANNEL_CODE,
  input wire logic PASS_STATUS,
  input wire logic GENERAL_PIN_0_I,
  output logic GENERAL_PIN_0_O,
  output logic GENERAL_PIN_0_OE,
  input wire logic GENERAL_PIN_3_I,
  output logic GENERAL_PIN_3_O,
  output logic GENERAL_PIN_3_OE,
  output logic GENERAL_PIN_0_LEVEL,
  output logic GENERAL_PIN_3_LEVEL
);

  if (RAW_W < 1 || RAW_W > BUS_W) $error("cor_regs: need 1 <= RAW_W <= BUS_W");

  // ****************************************
  // bus slave
  // ****************************************
  logic req;
  logic wr_take;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] rdata_d;
  cor_slot_e slot;

  assign req = WB_CYC_I && WB_STB_I;
  assign slot = cor_decode(WB_ADR_I[COR_ADR_W-1:COR_ADR_LSB]);
  // write lands on the edge where the master samples ack
  assign wr_take = req && WB_WE_I && ack_q && WB_SEL_I[0];

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      ack_q <= 1'b0;
    else
      ack_q <= req && !ack_q;
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;

  // ****************************************
  // register storage
  // ****************************************
  logic [7:0] trail_q;
  logic [7:0] exit_q;
  logic [7:0] lpx_q;
  logic [7:0] raw_q;
  logic [7:0] port0_q;
  logic [7:0] port1_q;
  logic [7:1] route_q;
  logic [7:0] vc_q;
  logic pass_sync;

  // reserved bits are kept as storage too
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      trail_q <= COR_RST_HS_TRAIL;
      exit_q <= COR_RST_HS_EXIT;
      lpx_q <= COR_RST_LP_PULSE;
      raw_q <= COR_RST_RAW_PLACE;
    end
    else if (wr_take)
    begin
      case (slot)
        COR_SLOT_TRAIL: trail_q <= WB_DAT_I[7:0];
        COR_SLOT_EXIT: exit_q <= WB_DAT_I[7:0];
        COR_SLOT_LPX: lpx_q <= WB_DAT_I[7:0];
        COR_SLOT_RAW: raw_q <= WB_DAT_I[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      port0_q <= COR_RST_PORT0;
      port1_q <= COR_RST_PORT1;
    end
    else if (wr_take)
    begin
      case (slot)
        COR_SLOT_PORT0: port0_q <= WB_DAT_I[7:0];
        COR_SLOT_PORT1: port1_q <= WB_DAT_I[7:0];
        default: ;
      endcase
    end
  end

  // status bit 0 is live, so only bits 7:1 are stored
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      route_q <= COR_RST_ROUTING[7:1];
      vc_q <= COR_RST_VC;
    end
    else if (wr_take)
    begin
      case (slot)
        COR_SLOT_ROUTE: route_q <= WB_DAT_I[7:1];
        COR_SLOT_VC: vc_q <= WB_DAT_I[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb
  begin
    case (slot)
      COR_SLOT_TRAIL: rdata_d = trail_q;
      COR_SLOT_EXIT: rdata_d = exit_q;
      COR_SLOT_LPX: rdata_d = lpx_q;
      COR_SLOT_RAW: rdata_d = raw_q;
      COR_SLOT_PORT0: rdata_d = port0_q;
      COR_SLOT_PORT1: rdata_d = port1_q;
      COR_SLOT_ROUTE: rdata_d = {route_q, pass_sync};
      COR_SLOT_VC: rdata_d = vc_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata_q <= 32'h0000_0000;
    else if (req && !ack_q)
      rdata_q <= {24'h00_0000, rdata_d};
  end

  // ****************************************
  // transmitter timing
  // ****************************************
  cor_timing_sel #(.W(COR_TRAIL_W)) u_trail (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .override_en(trail_q[COR_OVR_BIT]),
    .override_val(trail_q[COR_TRAIL_W-1:0]),
    .auto_val(AUTO_TIMING.trail),
    .timing_q(TX_TIMING.trail)
  );

  cor_timing_sel #(.W(COR_EXIT_W)) u_exit (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .override_en(exit_q[COR_OVR_BIT]),
    .override_val(exit_q[COR_EXIT_W-1:0]),
    .auto_val(AUTO_TIMING.hs_exit),
    .timing_q(TX_TIMING.hs_exit)
  );

  cor_timing_sel #(.W(COR_LPX_W)) u_lpx (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .override_en(lpx_q[COR_OVR_BIT]),
    .override_val(lpx_q[COR_LPX_W-1:0]),
    .auto_val(AUTO_TIMING.lpx),
    .timing_q(TX_TIMING.lpx)
  );

  // ****************************************
  // raw placement, ports, channel
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      COLOUR_BUS <= '0;
    else if (raw_q[COR_RAW_MSB_BIT])
      COLOUR_BUS <= {RAW_PIXEL, {(BUS_W-RAW_W){1'b0}}};
    else
      COLOUR_BUS <= {{(BUS_W-RAW_W){1'b0}}, RAW_PIXEL};
  end

  assign PORT0_CFG.reg_control = port0_q[COR_RCTL_BIT];
  assign PORT0_CFG.lane_enable = port0_q[COR_LANE_W-1:0];
  assign PORT1_CFG.reg_control = port1_q[COR_RCTL_BIT];
  assign PORT1_CFG.lane_enable = port1_q[COR_LANE_W-1:0];
  assign VIRTUAL_CHANNEL_CODE = vc_q[COR_VC_LSB +: COR_VC_W];

  // ****************************************
  // status pin routing
  // ****************************************
  logic [2:0] pins_sync;

  // pass status and pin levels come from outside this clock
  cor_sync2 #(.W(3)) u_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .async_in({PASS_STATUS, GENERAL_PIN_3_I, GENERAL_PIN_0_I}),
    .sync_out(pins_sync)
  );

  assign pass_sync = pins_sync[2];
  assign GENERAL_PIN_3_LEVEL = pins_sync[1];
  assign GENERAL_PIN_0_LEVEL = pins_sync[0];

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      GENERAL_PIN_0_OE <= 1'b0;
      GENERAL_PIN_0_O <= 1'b0;
      GENERAL_PIN_3_OE <= 1'b0;
      GENERAL_PIN_3_O <= 1'b0;
    end
    else
    begin
      GENERAL_PIN_0_OE <= route_q[COR_PIN0_BIT];
      GENERAL_PIN_0_O <= route_q[COR_PIN0_BIT] && pass_sync;
      GENERAL_PIN_3_OE <= route_q[COR_PIN3_BIT];
      GENERAL_PIN_3_O <= route_q[COR_PIN3_BIT] && pass_sync;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence wr_hit(logic [5:0] idx);
    wr_take && WB_ADR_I[COR_ADR_W-1:COR_ADR_LSB] == idx;
  endsequence

  sequence rd_req(logic [5:0] idx);
    req && !WB_WE_I && !ack_q && WB_ADR_I[COR_ADR_W-1:COR_ADR_LSB] == idx;
  endsequence

  ack_single_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held for more than one cycle");

  ack_latency_a: assert property (req && !ack_q |=> WB_ACK_O)
    else $error("ack not given one cycle after request");

  // the edge after reset release still shows the reset value of the timing flop
  trail_select_a: assert property ($past(RST_N) |->
    TX_TIMING.trail == ($past(trail_q[COR_OVR_BIT]) ? $past(trail_q[3:0]) : $past(AUTO_TIMING.trail)))
    else $error("trail timing source wrong");

  exit_select_a: assert property ($past(RST_N) |->
    TX_TIMING.hs_exit == ($past(exit_q[COR_OVR_BIT]) ? $past(exit_q[4:0]) : $past(AUTO_TIMING.hs_exit)))
    else $error("exit timing source wrong");

  lpx_auto_a: assert property (
    RST_N && !lpx_q[COR_OVR_BIT] ##1 1'b1 |-> TX_TIMING.lpx == $past(AUTO_TIMING.lpx))
    else $error("pulse timing not automatic");

  raw_msb_a: assert property (
    raw_q[COR_RAW_MSB_BIT] |=> COLOUR_BUS[BUS_W-1 -: RAW_W] == $past(RAW_PIXEL))
    else $error("raw data not on msbs");

  port0_write_a: assert property (wr_hit(COR_IDX_PORT0) |=>
    PORT0_CFG.lane_enable == $past(WB_DAT_I[5:0]) && PORT0_CFG.reg_control == $past(WB_DAT_I[7]))
    else $error("port 0 write not applied");

  port1_write_a: assert property (wr_hit(COR_IDX_PORT1) |=>
    PORT1_CFG.lane_enable == $past(WB_DAT_I[5:0]) && PORT1_CFG.reg_control == $past(WB_DAT_I[7]))
    else $error("port 1 write not applied");

  pin3_route_a: assert property (wr_hit(COR_IDX_ROUTING) ##1 1'b1 |=>
    GENERAL_PIN_3_OE == $past(route_q[COR_PIN3_BIT]) && (GENERAL_PIN_3_O -> GENERAL_PIN_3_OE))
    else $error("pin 3 routing wrong");

  pin0_route_a: assert property ($rose(route_q[COR_PIN0_BIT]) |=>
    GENERAL_PIN_0_OE && GENERAL_PIN_0_O == $past(pass_sync))
    else $error("pin 0 routing wrong");

  pass_read_a: assert property (rd_req(COR_IDX_ROUTING) |=>
    WB_ACK_O && WB_DAT_O[COR_PASS_BIT] == $past(pass_sync))
    else $error("pass status not shown");

  vc_write_a: assert property (wr_hit(COR_IDX_VC) |=>
    VIRTUAL_CHANNEL_CODE == $past(WB_DAT_I[7:6]))
    else $error("channel code not applied");

  trail_readback_a: assert property (rd_req(COR_IDX_HS_TRAIL) |=>
    WB_DAT_O[7:0] == $past(trail_q))
    else $error("trail value readback wrong");

  raw_reserved_a: assert property (wr_hit(COR_IDX_RAW_PLACE) |=>
    raw_q == $past(WB_DAT_I[7:0]))
    else $error("reserved bits not stored");

endmodule : cor_regs
`default_nettype wire

//--- hdl/cor_pkg.sv
`default_nettype none
package cor_pkg;

  // ****************************************
  // register indices (byte address = 4 x index)
  // ****************************************
  localparam int COR_IDX_W = 6;
  localparam int COR_ADR_W = 8;
  localparam int COR_ADR_LSB = 2;
  localparam logic [5:0] COR_IDX_HS_TRAIL = 6'h06;
  localparam logic [5:0] COR_IDX_HS_EXIT = 6'h07;
  localparam logic [5:0] COR_IDX_LP_PULSE = 6'h08;
  localparam logic [5:0] COR_IDX_RAW_PLACE = 6'h09;
  localparam logic [5:0] COR_IDX_PORT0 = 6'h13;
  localparam logic [5:0] COR_IDX_PORT1 = 6'h14;
  localparam logic [5:0] COR_IDX_ROUTING = 6'h16;
  localparam logic [5:0] COR_IDX_VC = 6'h2e;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [7:0] COR_RST_HS_TRAIL = 8'h00;
  localparam logic [7:0] COR_RST_HS_EXIT = 8'h00;
  localparam logic [7:0] COR_RST_LP_PULSE = 8'h00;
  localparam logic [7:0] COR_RST_RAW_PLACE = 8'h00;
  localparam logic [7:0] COR_RST_PORT0 = 8'h3f;
  localparam logic [7:0] COR_RST_PORT1 = 8'h00;
  localparam logic [7:0] COR_RST_ROUTING = 8'h02;
  localparam logic [7:0] COR_RST_VC = 8'h00;

  // ****************************************
  // field positions and widths
  // ****************************************
  localparam int COR_OVR_BIT = 7;
  localparam int COR_TRAIL_W = 4;
  localparam int COR_EXIT_W = 5;
  localparam int COR_LPX_W = 4;
  localparam int COR_RAW_MSB_BIT = 4;
  localparam int COR_LANE_W = 6;
  localparam int COR_RCTL_BIT = 7;
  localparam int COR_PIN3_BIT = 2;
  localparam int COR_PIN0_BIT = 1;
  localparam int COR_PASS_BIT = 0;
  localparam int COR_VC_LSB = 6;
  localparam int COR_VC_W = 2;

  typedef enum {
    COR_SLOT_TRAIL,
    COR_SLOT_EXIT,
    COR_SLOT_LPX,
    COR_SLOT_RAW,
    COR_SLOT_PORT0,
    COR_SLOT_PORT1,
    COR_SLOT_ROUTE,
    COR_SLOT_VC,
    COR_SLOT_NONE
  } cor_slot_e;

  typedef struct packed {
    logic [COR_TRAIL_W-1:0] trail;
    logic [COR_EXIT_W-1:0] hs_exit;
    logic [COR_LPX_W-1:0] lpx;
  } cor_timing_s;

  typedef struct packed {
    logic reg_control;
    logic [COR_LANE_W-1:0] lane_enable;
  } cor_port_s;

  function automatic cor_slot_e cor_decode(input logic [COR_IDX_W-1:0] idx);
    case (idx)
      COR_IDX_HS_TRAIL: return COR_SLOT_TRAIL;
      COR_IDX_HS_EXIT: return COR_SLOT_EXIT;
      COR_IDX_LP_PULSE: return COR_SLOT_LPX;
      COR_IDX_RAW_PLACE: return COR_SLOT_RAW;
      COR_IDX_PORT0: return COR_SLOT_PORT0;
      COR_IDX_PORT1: return COR_SLOT_PORT1;
      COR_IDX_ROUTING: return COR_SLOT_ROUTE;
      COR_IDX_VC: return COR_SLOT_VC;
      default: return COR_SLOT_NONE;
    endcase
  endfunction : cor_decode

endpackage : cor_pkg
`default_nettype wire

//--- hdl/cor_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module cor_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // meta_q feeds only the second stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : cor_sync2
`default_nettype wire

//--- hdl/cor_timing_sel.sv
`timescale 1ns/1ps
`default_nettype none
module cor_timing_sel #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic override_en,
  input wire logic [W-1:0] override_val,
  input wire logic [W-1:0] auto_val,
  output logic [W-1:0] timing_q
);

  if (W < 1) $error("cor_timing_sel: W must be at least 1");

  // stored value is ignored while override is clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timing_q <= '0;
    else
      timing_q <= override_en ? override_val : auto_val;
  end

endmodule : cor_timing_sel
`default_nettype wire

//--- sim/cor_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("FAIL %s expected %h seen %h", nm, e, g); end end
module cor_regs_test
  import cor_pkg::*;
;
  // ****************************************
  // clock, reset and design
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  cor_timing_s auto_t = {4'h3, 5'h11, 4'h5};
  cor_timing_s tx_t;
  logic [11:0] raw = 12'habc;
  logic [23:0] colour;
  cor_port_s p0_cfg;
  cor_port_s p1_cfg;
  logic [1:0] vc;
  logic pass = 1'b0;
  logic ext0 = 1'b1;
  logic ext3 = 1'b1;
  logic p0_o, p0_oe, p3_o, p3_oe, p0_lvl, p3_lvl;
  // resolved pin level: the device wins while it drives, else the board
  wire p0_i = p0_oe ? p0_o : ext0;
  wire p3_i = p3_oe ? p3_o : ext3;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] rq;

  always #5 clk = ~clk;

  cor_regs i_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_SEL_I(4'h1), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .AUTO_TIMING(auto_t), .TX_TIMING(tx_t), .RAW_PIXEL(raw), .COLOUR_BUS(colour),
    .PORT0_CFG(p0_cfg), .PORT1_CFG(p1_cfg), .VIRTUAL_CHANNEL_CODE(vc), .PASS_STATUS(pass),
    .GENERAL_PIN_0_I(p0_i), .GENERAL_PIN_0_O(p0_o), .GENERAL_PIN_0_OE(p0_oe),
    .GENERAL_PIN_3_I(p3_i), .GENERAL_PIN_3_O(p3_o), .GENERAL_PIN_3_OE(p3_oe),
    .GENERAL_PIN_0_LEVEL(p0_lvl), .GENERAL_PIN_3_LEVEL(p3_lvl)
  );

  // ****************************************
  // bus cycles and closing
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // ack is sampled at the rising edge; the write lands and read data is taken there
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      failures++;
      print_verdict();
    end
    rq = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    logic [5:0] idx_l [8] = '{COR_IDX_HS_TRAIL, COR_IDX_HS_EXIT, COR_IDX_LP_PULSE, COR_IDX_RAW_PLACE,
                             COR_IDX_PORT0, COR_IDX_PORT1, COR_IDX_ROUTING, COR_IDX_VC};
    logic [7:0] rst_l [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h02, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b0, {idx_l[i], 2'b00}, 8'h00);
      `CHK("reset read", rst_l[i], rq)
    end
    `CHK("port0 cfg", 7'h3f, p0_cfg)
    `CHK("port1 cfg", 7'h00, p1_cfg)
    `CHK("pin0 oe", 1'b1, p0_oe)
    `CHK("pin3 oe", 1'b0, p3_oe)
    $display("reset test done");
  endtask : t_reset

  task automatic t_timing();
    wb(1'b1, {COR_IDX_HS_TRAIL, 2'b00}, 8'hfa);
    wb(1'b1, {COR_IDX_HS_EXIT, 2'b00}, 8'hf6);
    wb(1'b1, {COR_IDX_LP_PULSE, 2'b00}, 8'h89);
    wait_n(2);
    `CHK("override timing", {4'ha, 5'h16, 4'h9}, tx_t)
    wb(1'b1, {COR_IDX_HS_TRAIL, 2'b00}, 8'h7a);
    wb(1'b1, {COR_IDX_HS_EXIT, 2'b00}, 8'h16);
    wb(1'b1, {COR_IDX_LP_PULSE, 2'b00}, 8'h09);
    wait_n(2);
    `CHK("auto timing", auto_t, tx_t)
    wb(1'b0, {COR_IDX_HS_TRAIL, 2'b00}, 8'h00);
    `CHK("trail read", 8'h7a, rq)
    wb(1'b0, {COR_IDX_HS_EXIT, 2'b00}, 8'h00);
    `CHK("exit read", 8'h16, rq)
    $display("timing test done");
  endtask : t_timing

  task automatic t_raw();
    // reserved bits set around the placement bit must not move the data
    wb(1'b1, {COR_IDX_RAW_PLACE, 2'b00}, 8'hef);
    wait_n(2);
    `CHK("raw on lsbs", 24'h000abc, colour)
    wb(1'b1, {COR_IDX_RAW_PLACE, 2'b00}, 8'h10);
    wait_n(2);
    `CHK("raw on msbs", 24'habc000, colour)
    $display("raw test done");
  endtask : t_raw

  task automatic t_ports();
    wb(1'b1, {COR_IDX_PORT0, 2'b00}, 8'h00);
    wb(1'b1, {COR_IDX_PORT1, 2'b00}, 8'hff);
    wait_n(1);
    `CHK("port0 off", 7'h00, p0_cfg)
    `CHK("port1 on", 7'h7f, p1_cfg)
    wb(1'b0, {COR_IDX_PORT1, 2'b00}, 8'h00);
    `CHK("port1 read", 8'hff, rq)
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, {COR_IDX_VC, 2'b00}, {i[1:0], 6'h15});
      wait_n(1);
      `CHK("virtual channel", i[1:0], vc)
    end
    $display("port test done");
  endtask : t_ports

  task automatic t_route();
    @(posedge clk);
    pass <= 1'b1;
    wait_n(4);
    `CHK("pin0 pass", 2'b11, {p0_oe, p0_o})
    wb(1'b0, {COR_IDX_ROUTING, 2'b00}, 8'h00);
    `CHK("status read", 8'h03, rq)
    wb(1'b1, {COR_IDX_ROUTING, 2'b00}, 8'h04);
    wait_n(2);
    `CHK("pin3 pass", 2'b11, {p3_oe, p3_o})
    `CHK("pin0 released", 1'b0, p0_oe)
    @(posedge clk);
    pass <= 1'b0;
    wait_n(4);
    `CHK("pin3 low", 1'b0, p3_o)
    // the pin level needs two more edges through the synchroniser
    wait_n(2);
    `CHK("pin levels", 2'b10, {p0_lvl, p3_lvl})
    wb(1'b0, {COR_IDX_ROUTING, 2'b00}, 8'h00);
    `CHK("status read low", 8'h04, rq)
    // status bit 0 is live, so writing it stores nothing
    wb(1'b1, {COR_IDX_ROUTING, 2'b00}, 8'h07);
    wait_n(2);
    `CHK("pin0 restored", 2'b10, {p0_oe, p0_o})
    wb(1'b0, {COR_IDX_ROUTING, 2'b00}, 8'h00);
    `CHK("status bit0 live", 8'h06, rq)
    wb(1'b0, 8'h00, 8'h00);
    `CHK("unmapped read", 8'h00, rq)
    $display("routing test done");
  endtask : t_route

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_timing();
    t_raw();
    t_ports();
    t_route();
    print_verdict();
  end
endmodule : cor_regs_test
`default_nettype wire
